// >>> core/wwdt_pkg.sv
// shared constants, types and helpers of the windowed supervision timer
package wwdt_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [9:0] WWDT_IDX_CONTROL = 10'h000;
   localparam logic [9:0] WWDT_IDX_STATUS = 10'h001;
   localparam logic [9:0] WWDT_IDX_PROTECT = 10'h002;
   localparam logic [9:0] WWDT_IDX_STATE = 10'h003;
   localparam logic [9:0] WWDT_IDX_LAST = 10'h003;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int WWDT_LOCK_BIT = 7;
   localparam int WWDT_SYNC_BIT = 0;
   localparam logic [7:0] WWDT_CONTROL_RST = 8'h00;
   localparam logic [31:0] WWDT_PRDATA_RST = 32'h00000000;
   localparam logic [3:0] WWDT_CODE_OFF = 4'h0;
   localparam logic [3:0] WWDT_CODE_MAX = 4'hB;

   // ----------------------------------------------------------------
   // cycle and tick counts
   // ----------------------------------------------------------------
   localparam logic [2:0] WWDT_PROTECT_CYCLES = 3'h4;
   localparam logic [1:0] WWDT_CFG_SYNC_TICKS = 2'h2;
   localparam logic [1:0] WWDT_SVC_SYNC_TICKS = 2'h3;
   localparam logic [14:0] WWDT_BASE_TICKS = 15'h0008;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [3:0] closedTimeout;
      logic [3:0] openTimeout;
   } wwdt_cfg_s;

   typedef enum logic [1:0] {
      WWDT_OFF = 2'b00,
      WWDT_FREE = 2'b01,
      WWDT_CLOSED = 2'b10,
      WWDT_OPEN = 2'b11
   } wwdt_phase_e;

   // reserved codes above the last step act as the longest period
   function automatic logic [14:0] wwdt_len(input logic [3:0] code);
      logic [3:0] c;
      c = (code > WWDT_CODE_MAX) ? WWDT_CODE_MAX : code;
      wwdt_len = WWDT_BASE_TICKS << (c - 4'h1);
   endfunction : wwdt_len

endpackage : wwdt_pkg

// >>> core/wwdt_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ns
module wwdt_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= '0;
         syncOut <= '0;
      end else begin
         stage1 <= asyncIn;
         syncOut <= stage1;
      end
   end
endmodule : wwdt_sync

// >>> core/wwdt_core.sv
// windowed supervision timer with apb registers
// What this block does
// - nonzero open timeout code enables the timer
// - nonzero closed timeout code selects window mode
// - normal mode: missed service raises reset request
// - accepted service clears count, restarts period
// - eleven selectable periods for both windows
// - counter advances on slow oscillator tick
// - window mode: early service raises reset request
// - open period follows closed; missing it resets
// - closed window armed only after first service
// - lock blocks control writes; cleared only halted
// - boot fuse loads control; nonzero open code enables and locks
// - keeps counting on tick regardless of main activity
// - debug halt stops timer and clears count
// - restart after halt runs normal timeout first
// - control writes cross to tick domain, flagged pending
// - service takes two to three ticks to act
// - protected write without unlock leaves register unchanged
// - codes 1 to 11 give 8 doubling to 8K ticks
// - pending flag clears once crossing completes
`timescale 1ns/1ns
module wwdt_core
   import wwdt_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter logic [7:0] UNLOCK_KEY = 8'hA5
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic slowTickPin,
   input wire logic serviceReq,
   input wire logic debugHalt,
   input wire logic [7:0] bootConfigFuse,
   input wire logic resetAck,
   output logic sysResetReq
);

   // ----------------------------------------------------------------
   // slow tick recovery
   // ----------------------------------------------------------------
   logic tickSync;
   logic tickLast;
   wire logic tick = tickSync & ~tickLast;

   wwdt_sync #(
      .WIDTH(1)
   ) u_tickSync (
      .clk(clk),
      .rst_n(rst_n),
      .asyncIn(slowTickPin),
      .syncOut(tickSync)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) tickLast <= 1'b0;
      else tickLast <= tickSync;
   end

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   wire logic [9:0] regIdx = 10'(paddr[ADDR_W-1:2]);
   wire logic mapped = (paddr[1:0] == 2'b00) && (regIdx <= WWDT_IDX_LAST);
   wire logic setup = psel & ~penable;
   wire logic access = psel & penable;
   wire logic wrEn = access & pwrite & mapped;
   wire logic wrControl = wrEn && (regIdx == WWDT_IDX_CONTROL);
   wire logic wrStatus = wrEn && (regIdx == WWDT_IDX_STATUS);
   wire logic wrProtect = wrEn && (regIdx == WWDT_IDX_PROTECT);
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;

   // ----------------------------------------------------------------
   // change protection and lock
   // ----------------------------------------------------------------
   logic [2:0] protectLeft;
   logic lock;
   logic booted;
   wire logic protectOpen = (protectLeft != 3'h0);
   wire logic keyWrite = wrProtect && (pwdata[7:0] == UNLOCK_KEY);
   // protected write consumes the unlock window
   wire logic ctrlTake = wrControl & protectOpen & ~lock;
   wire logic lockSet = wrStatus & protectOpen & pwdata[WWDT_LOCK_BIT];
   wire logic lockClr = wrStatus & protectOpen & ~pwdata[WWDT_LOCK_BIT] & debugHalt;
   wire logic [2:0] next_protectLeft = keyWrite ? WWDT_PROTECT_CYCLES :
      ((ctrlTake | (wrStatus & protectOpen)) ? 3'h0 :
      (protectOpen ? protectLeft - 3'h1 : 3'h0));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) protectLeft <= 3'h0;
      else protectLeft <= next_protectLeft;
   end

   wwdt_cfg_s ctrl;
   wwdt_cfg_s activeCfg;
   wwdt_cfg_s fuseCfg;
   assign fuseCfg = bootConfigFuse;

   // fuse is a level, caught by a clocked process after release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         booted <= 1'b0;
         lock <= 1'b0;
         ctrl <= WWDT_CONTROL_RST;
      end else if (!booted) begin
         booted <= 1'b1;
         ctrl <= fuseCfg;
         lock <= (fuseCfg.openTimeout != WWDT_CODE_OFF);
      end else begin
         if (ctrlTake) ctrl <= pwdata[7:0];
         if (lockSet) lock <= 1'b1;
         else if (lockClr) lock <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // crossing of control and service into the tick domain
   // ----------------------------------------------------------------
   logic syncPending;
   logic [1:0] syncLeft;
   logic svcPending;
   logic [1:0] svcLeft;
   wire logic syncDone = syncPending & tick & (syncLeft == 2'h1);
   wire logic svcApply = svcPending & tick & (svcLeft == 2'h1);

   // rewrite while pending restarts the crossing; software avoids it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         syncPending <= 1'b0;
         syncLeft <= 2'h0;
      end else if (ctrlTake) begin
         syncPending <= 1'b1;
         syncLeft <= WWDT_CFG_SYNC_TICKS;
      end else if (syncDone) begin
         syncPending <= 1'b0;
         syncLeft <= 2'h0;
      end else if (syncPending & tick) begin
         syncLeft <= syncLeft - 2'h1;
      end
   end

   // a service arriving while one is in flight merges with it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         svcPending <= 1'b0;
         svcLeft <= 2'h0;
      end else if (svcApply) begin
         svcPending <= serviceReq;
         svcLeft <= WWDT_SVC_SYNC_TICKS;
      end else if (serviceReq & ~svcPending) begin
         svcPending <= 1'b1;
         svcLeft <= WWDT_SVC_SYNC_TICKS;
      end else if (svcPending & tick) begin
         svcLeft <= svcLeft - 2'h1;
      end
   end

   // ----------------------------------------------------------------
   // tick-domain configuration
   // ----------------------------------------------------------------
   wire logic cfgEnabled = (activeCfg.openTimeout != WWDT_CODE_OFF);
   wire logic cfgWindow = (activeCfg.closedTimeout != WWDT_CODE_OFF);
   wire logic [14:0] openLen = wwdt_len(activeCfg.openTimeout);
   wire logic [14:0] closedLen = wwdt_len(activeCfg.closedTimeout);
   wire logic windowTurnsOn = syncDone && (activeCfg.closedTimeout == WWDT_CODE_OFF) &&
      (ctrl.closedTimeout != WWDT_CODE_OFF);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) activeCfg <= WWDT_CONTROL_RST;
      else if (!booted) activeCfg <= fuseCfg;
      else if (syncDone) activeCfg <= ctrl;
   end

   // ----------------------------------------------------------------
   // counter and phase
   // ----------------------------------------------------------------
   wwdt_phase_e phase;
   wwdt_phase_e next_phase;
   logic [14:0] cnt;
   logic [14:0] next_cnt;
   logic trip;
   logic next_trip;
   wire logic [14:0] cntInc = cnt + 15'h0001;

   always_comb begin
      next_phase = phase;
      next_cnt = cnt;
      next_trip = 1'b0;
      if (!cfgEnabled) begin
         next_phase = WWDT_OFF;
         next_cnt = 15'h0000;
      end else if (debugHalt) begin
         next_phase = WWDT_FREE;
         next_cnt = 15'h0000;
      end else if (windowTurnsOn) begin
         next_phase = WWDT_FREE;
         next_cnt = 15'h0000;
      end else begin
         unique case (phase)
            WWDT_OFF, WWDT_FREE, WWDT_OPEN: begin
               // freshly enabled timer runs free until first service
               if (phase == WWDT_OFF) next_phase = WWDT_FREE;
               if (svcApply) begin
                  next_cnt = 15'h0000;
                  next_phase = cfgWindow ? WWDT_CLOSED : WWDT_FREE;
               end else if (tick) begin
                  if (cntInc >= openLen) begin
                     next_trip = 1'b1;
                     next_cnt = 15'h0000;
                  end else begin
                     next_cnt = cntInc;
                  end
               end
            end
            WWDT_CLOSED: begin
               if (!cfgWindow) begin
                  next_phase = WWDT_FREE;
               end else if (svcApply) begin
                  next_trip = 1'b1;
                  next_cnt = 15'h0000;
               end else if (tick) begin
                  if (cntInc >= closedLen) begin
                     next_phase = WWDT_OPEN;
                     next_cnt = 15'h0000;
                  end else begin
                     next_cnt = cntInc;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= WWDT_OFF;
         cnt <= 15'h0000;
         trip <= 1'b0;
      end else begin
         phase <= next_phase;
         cnt <= next_cnt;
         trip <= next_trip;
      end
   end

   // ----------------------------------------------------------------
   // reset request: a new trip wins over a same-cycle ack
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) sysResetReq <= 1'b0;
      else if (trip) sysResetReq <= 1'b1;
      else if (resetAck) sysResetReq <= 1'b0;
   end

   // ----------------------------------------------------------------
   // read path, captured in setup so data comes from flops
   // ----------------------------------------------------------------
   logic [7:0] readMux;
   always_comb begin
      readMux = 8'h00;
      unique case (regIdx)
         WWDT_IDX_CONTROL: readMux = ctrl;
         WWDT_IDX_STATUS: readMux = {lock, 6'h00, syncPending};
         WWDT_IDX_PROTECT: readMux = {7'h00, protectOpen};
         WWDT_IDX_STATE: readMux = {3'h0, sysResetReq, svcPending, phase, cfgEnabled};
         default: readMux = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) prdata <= WWDT_PRDATA_RST;
      else if (setup & ~pwrite) prdata <= mapped ? {24'h000000, readMux} : WWDT_PRDATA_RST;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_DISABLED_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
      !cfgEnabled |=> !trip)
      else $error("disabled timer raised a trip");

   AST_LOCK_HOLDS_CTRL: assert property (@(posedge clk) disable iff (!rst_n)
      booted && wrControl && lock |=> $stable(ctrl))
      else $error("locked control register changed");

   AST_UNPROTECTED_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      booted && wrControl && !protectOpen |=> $stable(ctrl))
      else $error("control changed without unlock");

   AST_LOCK_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
      booted && lock && !debugHalt |=> lock)
      else $error("lock cleared outside debug halt");

   AST_SYNC_DONE: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(syncPending) |-> (activeCfg == ctrl))
      else $error("pending cleared before config applied");

   AST_HALT_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
      debugHalt && cfgEnabled |=> (cnt == 15'h0000) && (phase == WWDT_FREE))
      else $error("halt did not clear the counter");

   AST_SERVICE_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
      svcApply && cfgEnabled && !debugHalt && !windowTurnsOn && (phase != WWDT_CLOSED)
      |=> (cnt == 15'h0000) && !trip)
      else $error("service did not restart the period");

   AST_EARLY_SERVICE: assert property (@(posedge clk) disable iff (!rst_n)
      svcApply && cfgEnabled && cfgWindow && !debugHalt && !windowTurnsOn &&
      (phase == WWDT_CLOSED) |=> trip ##1 sysResetReq)
      else $error("early service did not request reset");

   AST_TIMEOUT: assert property (@(posedge clk) disable iff (!rst_n)
      tick && !svcApply && cfgEnabled && !debugHalt && !windowTurnsOn &&
      (phase != WWDT_CLOSED) && (cntInc >= openLen) |=> trip ##1 sysResetReq)
      else $error("missed service did not request reset");

   AST_REQ_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      sysResetReq && !resetAck |=> sysResetReq)
      else $error("reset request dropped without ack");

   AST_SERVICE_LATENCY: assert property (@(posedge clk) disable iff (!rst_n)
      serviceReq && !svcPending |=> (!svcApply)[*2])
      else $error("service acted too soon");

   AST_PENDING_ON_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
      ctrlTake |=> syncPending)
      else $error("control write did not raise pending");

   AST_ENABLE_FREE: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(cfgEnabled) && !svcApply |=> (phase == WWDT_FREE))
      else $error("enabled timer not running free");

   AST_ACK_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
      sysResetReq && resetAck && !trip |=> !sysResetReq)
      else $error("acknowledged request still raised");

endmodule : wwdt_core

// >>> testbench/wwdt_cpu_model.sv
// processor side model: apb master, unlock sequence and service pulses
`timescale 1ns/1ns
module wwdt_cpu_model
   import wwdt_pkg::*;
#(
   parameter logic [7:0] KEY = 8'hA5
) (
   input wire logic clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic serviceReq
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      serviceReq = 1'b0;
   end

   // ----------------------------------------------------------------
   // bus transfer
   // ----------------------------------------------------------------
   task automatic apbXfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
         output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // no local limit: only the bench watchdog ends a stuck wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // stale data inverted so a late sample never matches
      pwdata <= ~wd;
   endtask : apbXfer

   // key first, protected write in the very next transfer
   task automatic protWrite(input logic [11:0] addr, input logic [31:0] wd);
      logic [31:0] rd;
      logic err;
      apbXfer(1'b1, {WWDT_IDX_PROTECT, 2'b00}, {24'h000000, KEY}, rd, err);
      apbXfer(1'b1, addr, wd, rd, err);
   endtask : protWrite

   task automatic service();
      @(posedge clk);
      serviceReq <= 1'b1;
      @(posedge clk);
      serviceReq <= 1'b0;
   endtask : service
endmodule : wwdt_cpu_model

// >>> testbench/wwdt_bench.sv
// self-checking bench of the windowed supervision timer
`timescale 1ns/1ns
module wwdt_bench
   import wwdt_pkg::*;
;
   localparam logic [11:0] A_CTRL = {WWDT_IDX_CONTROL, 2'b00};
   localparam logic [11:0] A_STAT = {WWDT_IDX_STATUS, 2'b00};
   localparam logic [11:0] A_STATE = {WWDT_IDX_STATE, 2'b00};
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0] tickDiv;
   logic serviceReq, debugHalt, resetAck, sysResetReq;
   logic [7:0] bootConfigFuse;
   int err_count, n_tests;

   // ----------------------------------------------------------------
   // clock, slow tick and instances
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      tickDiv = 3'h0;
      debugHalt = 1'b0;
      resetAck = 1'b0;
      bootConfigFuse = 8'h00;
      err_count = 0;
      n_tests = 0;
   end
   always #5 clk = ~clk;
   // one slow tick every 8 clk keeps long periods short
   always @(posedge clk) tickDiv <= tickDiv + 3'h1;

   wwdt_core i_wwdt_core (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .slowTickPin(tickDiv[2]), .serviceReq(serviceReq),
      .debugHalt(debugHalt), .bootConfigFuse(bootConfigFuse), .resetAck(resetAck),
      .sysResetReq(sysResetReq));
   wwdt_cpu_model i_wwdt_cpu_model (.clk(clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serviceReq(serviceReq));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic readReg(input string what, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic er;
      i_wwdt_cpu_model.apbXfer(1'b0, a, 32'h00000000, rd, er);
      chk(what, exp, rd);
   endtask : readReg

   task automatic ticks(input int n);
      repeat (n * 8) @(posedge clk);
   endtask : ticks

   // quiet for lo ticks, then request within hi ticks
   task automatic expectTrip(input int lo, input int hi);
      int i;
      ticks(lo);
      chk("earlyTrip", 32'h0, {31'h0, sysResetReq});
      i = 0;
      while (sysResetReq !== 1'b1 && i < (hi - lo) * 8) begin
         @(posedge clk);
         i++;
      end
      chk("trip", 32'h1, {31'h0, sysResetReq});
   endtask : expectTrip

   task automatic ackReset();
      resetAck <= 1'b1;
      @(posedge clk);
      resetAck <= 1'b0;
      repeat (2) @(posedge clk);
      chk("ackClear", 32'h0, {31'h0, sysResetReq});
   endtask : ackReset

   task automatic doReset(input logic [7:0] fuse);
      rst_n <= 1'b0;
      debugHalt <= 1'b0;
      bootConfigFuse <= fuse;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask : doReset

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic testReset();
      logic [31:0] rd;
      logic er;
      doReset(8'h00);
      readReg("ctrlRst", A_CTRL, 32'h0);
      readReg("statRst", A_STAT, 32'h0);
      i_wwdt_cpu_model.apbXfer(1'b0, 12'h010, 32'h0, rd, er);
      chk("unmappedErr", 32'h1, {31'h0, er});
      chk("unmappedData", 32'h0, rd);
      chk("ready", 32'h1, {31'h0, pready});
      i_wwdt_cpu_model.apbXfer(1'b1, A_CTRL, 32'h01, rd, er);
      ticks(20);
      readReg("ctrlNoKey", A_CTRL, 32'h0);
      chk("offNoTrip", 32'h0, {31'h0, sysResetReq});
      $display("test reset finished");
   endtask : testReset

   task automatic testNormal();
      doReset(8'h00);
      i_wwdt_cpu_model.protWrite(A_CTRL, 32'h01);
      readReg("pendSet", A_STAT, 32'h1);
      ticks(3);
      readReg("pendClr", A_STAT, 32'h0);
      repeat (8) begin
         i_wwdt_cpu_model.service();
         ticks(4);
      end
      chk("serviced", 32'h0, {31'h0, sysResetReq});
      expectTrip(5, 9);
      ackReset();
      $display("test normal finished");
   endtask : testNormal

   task automatic testWindow();
      doReset(8'h00);
      i_wwdt_cpu_model.protWrite(A_CTRL, 32'h11);
      ticks(3);
      readReg("freeBeforeSvc", A_STATE, 32'h03);
      i_wwdt_cpu_model.service();
      ticks(4);
      readReg("closedAfterSvc", A_STATE, 32'h05);
      expectTrip(13, 20);
      ackReset();
      doReset(8'h00);
      i_wwdt_cpu_model.protWrite(A_CTRL, 32'h11);
      ticks(3);
      i_wwdt_cpu_model.service();
      ticks(5);
      i_wwdt_cpu_model.service();
      expectTrip(0, 5);
      $display("test window finished");
   endtask : testWindow

   task automatic testLock();
      doReset(8'h00);
      i_wwdt_cpu_model.protWrite(A_STAT, 32'h80);
      readReg("lockSet", A_STAT, 32'h80);
      i_wwdt_cpu_model.protWrite(A_CTRL, 32'h03);
      readReg("ctrlLocked", A_CTRL, 32'h0);
      i_wwdt_cpu_model.protWrite(A_STAT, 32'h00);
      readReg("lockStays", A_STAT, 32'h80);
      debugHalt <= 1'b1;
      i_wwdt_cpu_model.protWrite(A_STAT, 32'h00);
      readReg("lockClrHalt", A_STAT, 32'h0);
      i_wwdt_cpu_model.protWrite(A_CTRL, 32'h11);
      ticks(20);
      chk("haltNoTrip", 32'h0, {31'h0, sysResetReq});
      debugHalt <= 1'b0;
      // window mode left unserviced: plain timeout after restart
      expectTrip(6, 12);
      $display("test lock finished");
   endtask : testLock

   task automatic testFuse();
      doReset(8'h02);
      readReg("ctrlFuse", A_CTRL, 32'h02);
      readReg("lockFuse", A_STAT, 32'h80);
      expectTrip(13, 18);
      $display("test fuse finished");
   endtask : testFuse

   // ----------------------------------------------------------------
   // sequence, watchdog and verdict
   // ----------------------------------------------------------------
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done

   initial begin
      testReset();
      testNormal();
      testWindow();
      testLock();
      testFuse();
      test_done();
   end

   // all scenarios need well under 20000 cycles
   initial begin
      #200000;
      err_count++;
      test_done();
   end
endmodule : wwdt_bench
